// ### buck_seq_consts.svh
// offsets, field positions, reset values and timing counts of the sequencer
`ifndef BUCK_SEQ_CONSTS_SVH
`define BUCK_SEQ_CONSTS_SVH

// register offsets
`define ADDR_CTRL 4'h0
`define ADDR_CONFIG 4'h1
`define ADDR_STATUS 4'h2
`define ADDR_STATE 4'h3

// control register fields
`define CTRL_ON_OFF 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 2
`define CTRL_HICCUP 3
`define CTRL_FCCM 4
`define CTRL_RESET 16'h0008

// configuration register fields
`define CFG_POD_LO 0
`define CFG_POD_HI 2
`define CFG_SST_LO 3
`define CFG_SST_HI 4
`define CFG_PGD_LO 5
`define CFG_PGD_HI 7
`define CFG_FS_LO 8
`define CFG_FS_HI 10
`define CFG_RESET 16'h0000

// status register bits
`define ST_IOUT_OC 0
`define ST_IOUT 1
`define ST_VIN_UV 2
`define ST_INPUT 3
`define ST_OUT_LOW 4
`define ST_OUT_HIGH 5

// clock and time base
`define CLK_PERIOD_NS 25
`define CLK_KHZ (1000000 / `CLK_PERIOD_NS)
`define TICK_NS 1000
`define TICK_CYCLES ((`TICK_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// gate timing, least times rounded up
`define DEAD_HL_NS 10
`define DEAD_LH_NS 20
`define MIN_OFF_NS 320
`define MIN_ON_NS 60
`define CYC_UP(ns) ((ns + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// protection and sequence times in microsecond ticks, plus the hiccup soft-start multiple and the ramp full scale
`define UV_DELAY_US 1000
`define PG_FALL_US 2
`define HICCUP_BASE_US 8960
`define HICCUP_SS_MULT 7
`define SS_BASE_US 1000
`define RAMP_FULL_SCALE 67108864

`endif

// ### buck_seq_pkg.sv
// types shared by the buck start-up and protection sequencer
package buck_seq_pkg;

    // comparator and sense inputs from the analog front end
    typedef struct packed {
        logic fb_below_ref;
        logic fb_low_uv;
        logic fb_high_ov;
        logic fb_high_oob;
        logic in_inner;
        logic out_outer;
        logic cur_over_pos;
        logic cur_below_neg;
        logic zero_cross;
        logic supply_low;
    } sense_s;

    typedef enum logic [6:0] {
        SEQ_OFF = 7'b0000001,
        SEQ_DELAY = 7'b0000010,
        SEQ_RAMP = 7'b0000100,
        SEQ_RUN = 7'b0001000,
        SEQ_HICCUP = 7'b0010000,
        SEQ_UVSTOP = 7'b0100000,
        SEQ_OVLATCH = 7'b1000000
    } seq_e;

    typedef enum logic [4:0] {
        SW_IDLE = 5'b00001,
        SW_HIGH = 5'b00010,
        SW_DEAD_HL = 5'b00100,
        SW_LOW = 5'b01000,
        SW_DEAD_LH = 5'b10000
    } sw_e;

    typedef logic [17:0] ticks_t;

endpackage

// ### buck_seq.sv
// start-up sequencing, gate timing and protection of a single buck channel
`timescale 1ns/1ps
`default_nettype none
`include "buck_seq_consts.svh"

module buck_seq #(
    parameter int TICK_CYCLES = `TICK_CYCLES
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire logic i_enable_pin,
    input wire buck_seq_pkg::sense_s i_sense,
    input wire logic [7:0] i_duty,
    input wire logic i_pgood_pin,
    input wire logic [3:0] i_addr,
    input wire logic [15:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [15:0] o_rdata,
    output logic o_high_side_gate,
    output logic o_low_side_gate,
    output logic o_discharge,
    output logic [9:0] o_ref_level,
    output logic o_pgood_out,
    output logic o_pgood_oe_n
);
    import buck_seq_pkg::*;

    localparam logic [7:0] DEAD_HL_CYC = 8'(`CYC_UP(`DEAD_HL_NS));
    localparam logic [7:0] DEAD_LH_CYC = 8'(`CYC_UP(`DEAD_LH_NS));
    localparam logic [7:0] MIN_OFF_CYC = 8'(`CYC_UP(`MIN_OFF_NS));
    localparam logic [7:0] MIN_ON_CYC = 8'(`CYC_UP(`MIN_ON_NS));
    localparam logic [25:0] RAMP_INC = 26'(`RAMP_FULL_SCALE / `SS_BASE_US);

    logic [15:0] ctrl;
    logic [15:0] config_reg;
    logic [5:0] status;
    logic [5:0] status_set;
    logic [5:0] status_clr;
    seq_e seq;
    sw_e sw;
    sw_e next_sw;
    ticks_t seq_cnt;
    ticks_t uv_cnt;
    ticks_t pg_cnt;
    logic [7:0] sw_cnt;
    logic [7:0] next_sw_cnt;
    logic [7:0] off_cnt;
    logic [5:0] tick_cnt;
    logic tick;
    logic [25:0] ref_acc;
    logic pg;
    logic req;
    logic switching_ok;
    logic ov_mode;
    logic dcm;
    logic want_on;
    logic uv_trip;
    logic [7:0] ton;

    // power-on delay per select code, in microseconds
    function automatic ticks_t pod_us(input logic [2:0] sel);
        unique case (sel)
            3'h0: pod_us = 18'd350;
            3'h1: pod_us = 18'd600;
            3'h2: pod_us = 18'd1100;
            3'h3: pod_us = 18'd2148;
            3'h4: pod_us = 18'd4196;
            3'h5: pod_us = 18'd8292;
            3'h6: pod_us = 18'd16480;
            default: pod_us = 18'd32860;
        endcase
    endfunction

    // power-good delay per select code, in microseconds
    function automatic ticks_t pgd_us(input logic [2:0] sel);
        unique case (sel)
            3'h0: pgd_us = 18'd256;
            3'h1: pgd_us = 18'd512;
            3'h2: pgd_us = 18'd1024;
            3'h3: pgd_us = 18'd2048;
            3'h4: pgd_us = 18'd4096;
            3'h5: pgd_us = 18'd8192;
            3'h6: pgd_us = 18'd16380;
            default: pgd_us = 18'd131000;
        endcase
    endfunction

    // soft-start time doubles per step of the select code
    function automatic ticks_t ss_us(input logic [1:0] sel);
        ss_us = ticks_t'(`SS_BASE_US) << sel;
    endfunction

    // switching period in clock cycles for the preset frequency
    function automatic logic [7:0] period_cyc(input logic [2:0] sel);
        int khz;
        unique case (sel)
            3'h0: khz = 275;
            3'h1: khz = 325;
            3'h2: khz = 425;
            3'h3: khz = 525;
            3'h4: khz = 625;
            3'h5: khz = 750;
            3'h6: khz = 850;
            default: khz = 1000;
        endcase
        period_cyc = 8'(`CLK_KHZ / khz);
    endfunction

    // microsecond tick for all long timers; shorten TICK_CYCLES in simulation
    always_ff @(posedge i_mclk) begin
        if (i_srst || tick) begin
            tick_cnt <= 6'h00;
        end else begin
            tick_cnt <= tick_cnt + 6'h01;
        end
    end
    assign tick = (tick_cnt == 6'(TICK_CYCLES - 1));

    // run request: 0 pin only, 1 bit only, 2 pin and bit, 3 pin or bit
    always_comb begin
        unique case (ctrl[`CTRL_OP_HI:`CTRL_OP_LO])
            2'h0: req = i_enable_pin;
            2'h1: req = ctrl[`CTRL_ON_OFF];
            2'h2: req = i_enable_pin && ctrl[`CTRL_ON_OFF];
            default: req = i_enable_pin || ctrl[`CTRL_ON_OFF];
        endcase
    end

    assign switching_ok = ((seq == SEQ_RAMP) || (seq == SEQ_RUN)) && !i_sense.supply_low;
    // a disable or lockout releases the latched low side in the same cycle
    assign ov_mode = (seq == SEQ_OVLATCH) && req && !i_sense.supply_low;
    // the ramp always runs in skip mode; forced continuous only afterwards
    assign dcm = (seq == SEQ_RAMP) || !ctrl[`CTRL_FCCM];
    assign uv_trip = (uv_cnt == ticks_t'(`UV_DELAY_US));

    // control and configuration registers
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ctrl <= `CTRL_RESET;
            config_reg <= `CFG_RESET;
        end else if (i_wr) begin
            if (i_addr == `ADDR_CTRL) begin
                ctrl <= i_wdata;
            end
            if (i_addr == `ADDR_CONFIG) begin
                config_reg <= i_wdata;
            end
        end
    end

    // sequence: off, power-on delay, ramp, run, and the fault stops
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            seq <= SEQ_OFF;
            seq_cnt <= '0;
        end else if (!req || i_sense.supply_low) begin
            seq <= SEQ_OFF;
            seq_cnt <= '0;
        end else begin
            unique case (seq)
                SEQ_OFF: begin
                    seq <= SEQ_DELAY;
                    seq_cnt <= '0;
                end
                SEQ_DELAY: begin
                    if (tick) begin
                        if (seq_cnt >= pod_us(config_reg[`CFG_POD_HI:`CFG_POD_LO]) - 18'd1) begin
                            seq <= SEQ_RAMP;
                            seq_cnt <= '0;
                        end else begin
                            seq_cnt <= seq_cnt + 18'd1;
                        end
                    end
                end
                SEQ_RAMP: begin
                    if (i_sense.fb_high_ov) begin
                        seq <= SEQ_OVLATCH;
                    end else if (tick) begin
                        if (seq_cnt >= ss_us(config_reg[`CFG_SST_HI:`CFG_SST_LO]) - 18'd1) begin
                            seq <= SEQ_RUN;
                            seq_cnt <= '0;
                        end else begin
                            seq_cnt <= seq_cnt + 18'd1;
                        end
                    end
                end
                SEQ_RUN: begin
                    if (i_sense.fb_high_ov) begin
                        seq <= SEQ_OVLATCH;
                    end else if (uv_trip) begin
                        seq <= ctrl[`CTRL_HICCUP] ? SEQ_HICCUP : SEQ_UVSTOP;
                        seq_cnt <= '0;
                    end
                end
                SEQ_HICCUP: begin
                    // restart with a fresh ramp; repeats while the fault stays
                    if (tick) begin
                        if (seq_cnt >= ticks_t'(`HICCUP_BASE_US) - 18'd1
                            + 18'(`HICCUP_SS_MULT) * ss_us(config_reg[`CFG_SST_HI:`CFG_SST_LO])) begin
                            seq <= SEQ_RAMP;
                            seq_cnt <= '0;
                        end else begin
                            seq_cnt <= seq_cnt + 18'd1;
                        end
                    end
                end
                SEQ_UVSTOP, SEQ_OVLATCH: begin
                    seq <= seq; // held until disabled or locked out by low supply
                end
                default: begin
                    seq <= SEQ_OFF;
                    seq_cnt <= '0;
                end
            endcase
        end
    end

    // output-low filter, armed only in run after the ramp
    always_ff @(posedge i_mclk) begin
        if (i_srst || (seq != SEQ_RUN) || !i_sense.fb_low_uv) begin
            uv_cnt <= '0;
        end else if (tick && !uv_trip) begin
            uv_cnt <= uv_cnt + 18'd1;
        end
    end

    // reference ramp as a fraction accumulator, full scale at the end
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            ref_acc <= '0;
        end else if (seq == SEQ_RAMP) begin
            if (tick) begin
                ref_acc <= ref_acc + (RAMP_INC >> config_reg[`CFG_SST_HI:`CFG_SST_LO]);
            end
        end else if ((seq == SEQ_RUN) || (seq == SEQ_OVLATCH)) begin
            ref_acc <= '1;
        end else begin
            ref_acc <= '0;
        end
    end
    assign o_ref_level = ref_acc[25:16];

    // power-good qualify and drop timers
    always_ff @(posedge i_mclk) begin
        if (i_srst || (seq != SEQ_RUN)) begin
            pg <= 1'b0;
            pg_cnt <= '0;
        end else if (!pg) begin
            if (!i_sense.in_inner) begin
                pg_cnt <= '0;
            end else if (tick) begin
                if (pg_cnt >= pgd_us(config_reg[`CFG_PGD_HI:`CFG_PGD_LO]) - 18'd1) begin
                    pg <= 1'b1;
                    pg_cnt <= '0;
                end else begin
                    pg_cnt <= pg_cnt + 18'd1;
                end
            end
        end else begin
            if (!i_sense.out_outer) begin
                pg_cnt <= '0;
            end else if (tick) begin
                if (pg_cnt >= ticks_t'(`PG_FALL_US) - 18'd1) begin
                    pg <= 1'b0;
                    pg_cnt <= '0;
                end else begin
                    pg_cnt <= pg_cnt + 18'd1;
                end
            end
        end
    end
    // open drain: drive low while not good, release when good
    assign o_pgood_oe_n = pg;
    assign o_pgood_out = 1'b0;

    // adaptive on-time: duty feed-forward scaled by the preset period
    always_comb begin
        ton = 8'((16'(period_cyc(config_reg[`CFG_FS_HI:`CFG_FS_LO])) * 16'(i_duty)) >> 8);
        if (ton < MIN_ON_CYC) begin
            ton = MIN_ON_CYC;
        end
    end

    // a new on pulse needs low feedback, valley under trip, no early-high guard
    assign want_on = switching_ok && i_sense.fb_below_ref && !i_sense.cur_over_pos
        && !i_sense.fb_high_oob && (off_cnt >= MIN_OFF_CYC);

    // gate sequencing with dead time on every handover
    always_comb begin
        next_sw = sw;
        next_sw_cnt = sw_cnt + 8'h01;
        unique case (sw)
            SW_IDLE: begin
                next_sw_cnt = 8'h00;
                if (ov_mode) begin
                    next_sw = SW_LOW;
                end else if (want_on) begin
                    next_sw = SW_HIGH;
                end
            end
            SW_HIGH: begin
                if (!switching_ok && !ov_mode) begin
                    next_sw = SW_IDLE;
                end else if (sw_cnt >= ton - 8'h01) begin
                    next_sw = SW_DEAD_HL;
                    next_sw_cnt = 8'h00;
                end
            end
            SW_DEAD_HL: begin
                if (sw_cnt >= DEAD_HL_CYC - 8'h01) begin
                    next_sw = (switching_ok || ov_mode) ? SW_LOW : SW_IDLE;
                    next_sw_cnt = 8'h00;
                end
            end
            SW_LOW: begin
                next_sw_cnt = 8'h00;
                if (ov_mode) begin
                    if (i_sense.cur_below_neg) begin
                        next_sw = SW_DEAD_LH;
                    end
                end else if (!switching_ok) begin
                    next_sw = SW_IDLE;
                end else if (want_on) begin
                    next_sw = SW_DEAD_LH;
                end else if (dcm && i_sense.zero_cross) begin
                    next_sw = SW_IDLE;
                end else if (!dcm && i_sense.cur_below_neg) begin
                    next_sw = SW_IDLE;
                end
            end
            SW_DEAD_LH: begin
                if (sw_cnt >= DEAD_LH_CYC - 8'h01) begin
                    next_sw = (ov_mode || want_on) ? SW_HIGH : SW_IDLE;
                    next_sw_cnt = 8'h00;
                end
            end
            default: begin
                next_sw = SW_IDLE;
                next_sw_cnt = 8'h00;
            end
        endcase
    end

    // gates come from flops loaded with the next state
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            sw <= SW_IDLE;
            sw_cnt <= 8'h00;
            o_high_side_gate <= 1'b0;
            o_low_side_gate <= 1'b0;
        end else begin
            sw <= next_sw;
            sw_cnt <= next_sw_cnt;
            o_high_side_gate <= (next_sw == SW_HIGH);
            o_low_side_gate <= (next_sw == SW_LOW);
        end
    end

    // off-time counter since the high side last turned off, saturating
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            off_cnt <= MIN_OFF_CYC;
        end else if (sw == SW_HIGH) begin
            off_cnt <= 8'h00;
        end else if (off_cnt != 8'hff) begin
            off_cnt <= off_cnt + 8'h01;
        end
    end

    // discharge path whenever the channel is not requested
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_discharge <= 1'b1;
        end else begin
            o_discharge <= !req;
        end
    end

    // fault events; a set in the clearing cycle wins
    always_comb begin
        status_set = 6'h00;
        if ((sw == SW_LOW) && switching_ok && !ov_mode
            && (i_sense.cur_over_pos || (!dcm && i_sense.cur_below_neg))) begin
            status_set[`ST_IOUT_OC] = 1'b1;
            status_set[`ST_IOUT] = 1'b1;
        end
        if (i_sense.supply_low && req) begin
            status_set[`ST_VIN_UV] = 1'b1;
            status_set[`ST_INPUT] = 1'b1;
        end
        if ((seq == SEQ_RUN) && uv_trip) begin
            status_set[`ST_OUT_LOW] = 1'b1;
        end
        if (((seq == SEQ_RUN) || (seq == SEQ_RAMP)) && i_sense.fb_high_ov && req
            && !i_sense.supply_low) begin
            status_set[`ST_OUT_HIGH] = 1'b1;
        end
        status_clr = (i_wr && (i_addr == `ADDR_STATUS)) ? i_wdata[5:0] : 6'h00;
    end

    // sticky status, write one to clear
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            status <= 6'h00;
        end else begin
            status <= (status & ~status_clr) | status_set;
        end
    end

    // read port: data in the cycle after the strobe, zero elsewhere
    always_ff @(posedge i_mclk) begin
        if (i_srst) begin
            o_rdata <= 16'h0000;
        end else if (i_rd) begin
            unique case (i_addr)
                `ADDR_CTRL: o_rdata <= ctrl;
                `ADDR_CONFIG: o_rdata <= config_reg;
                `ADDR_STATUS: o_rdata <= {10'h000, status};
                `ADDR_STATE: o_rdata <= {2'h0, i_pgood_pin, pg, 5'(sw), seq};
                default: o_rdata <= 16'h0000;
            endcase
        end else begin
            o_rdata <= 16'h0000;
        end
    end

endmodule
`default_nettype wire

// ### power_stage_model.sv
// power stage model: inductor zero-current timing and the pulled-up power-good wire
`timescale 1ns/1ps
`default_nettype none
module power_stage_model #(
    parameter int DECAY = 20
) (
    input wire logic i_mclk,
    input wire logic i_low_side_gate,
    input wire logic i_pgood_out,
    input wire logic i_pgood_oe_n,
    output logic o_pgood_pin,
    output logic o_zero_cross
);
    int on_cnt = 0;
    // a released open-drain wire rises through the external pull-up
    assign o_pgood_pin = i_pgood_oe_n ? 1'b1 : i_pgood_out;
    // current decays to zero a fixed time after the low side closes
    always @(posedge i_mclk) begin
        on_cnt <= i_low_side_gate ? on_cnt + 1 : 0;
    end
    assign o_zero_cross = i_low_side_gate && (on_cnt >= DECAY);
endmodule
`default_nettype wire

// ### buck_seq_sva.sv
// assertions on gate timing, power-good and protection of the sequencer
`timescale 1ns/1ps
`default_nettype none
module buck_seq_sva #(
    parameter int TICK_CYCLES = 40
) (
    input wire logic i_mclk,
    input wire logic i_srst,
    input wire buck_seq_pkg::sense_s i_sense,
    input wire logic i_wr,
    input wire logic o_high_side_gate,
    input wire logic o_low_side_gate,
    input wire logic o_discharge,
    input wire logic o_pgood_oe_n
);
    import buck_seq_pkg::*;
    default clocking @(posedge i_mclk); endclocking
    default disable iff (i_srst);
    int inner_cnt = 0;
    int outer_cnt = 0;
    // run lengths of the window comparators, for power-good timing
    always_ff @(posedge i_mclk) begin
        inner_cnt <= i_sense.in_inner ? inner_cnt + 1 : 0;
        outer_cnt <= i_sense.out_outer ? outer_cnt + 1 : 0;
    end
    AST_NO_SHOOT: assert property (!(o_high_side_gate && o_low_side_gate))
        else $error("both gates on together");
    AST_DEAD_HL: assert property ($fell(o_high_side_gate) |-> !o_low_side_gate)
        else $error("no gap after high side off");
    AST_DEAD_LH: assert property ($fell(o_low_side_gate) |-> !o_high_side_gate)
        else $error("no gap after low side off");
    AST_OFF_DIS: assert property (o_discharge [*2] |-> !o_high_side_gate && !o_low_side_gate)
        else $error("gate on while discharging");
    AST_OV_LOW: assert property (o_low_side_gate && $past(i_sense.fb_high_ov) && !i_wr
        && !$past(i_wr) && !i_sense.cur_below_neg && !i_sense.supply_low |=> o_low_side_gate)
        else $error("low side left during overvoltage");
    AST_HOLD_OFF: assert property (!o_high_side_gate && !i_sense.cur_below_neg
        && !$past(i_sense.cur_below_neg) && (i_sense.cur_over_pos || i_sense.fb_high_oob)
        |=> !o_high_side_gate)
        else $error("high side on above trip");
    AST_PG_IDLE: assert property (o_discharge [*2] |-> !o_pgood_oe_n)
        else $error("power good while disabled");
    AST_PG_RISE: assert property ($rose(o_pgood_oe_n) |-> inner_cnt >= 245 * TICK_CYCLES)
        else $error("power good rose early");
    AST_PG_FALL: assert property (outer_cnt > 4 * TICK_CYCLES + 2 |-> !o_pgood_oe_n)
        else $error("power good held outside window");
    AST_LOCKOUT: assert property (i_sense.supply_low [*2] |-> !o_high_side_gate && !o_low_side_gate)
        else $error("switching under lockout");
    cover property ($rose(o_high_side_gate));
    cover property ($rose(o_pgood_oe_n));
    cover property (o_low_side_gate && i_sense.fb_high_ov);
endmodule
bind buck_seq buck_seq_sva #(.TICK_CYCLES(TICK_CYCLES)) sva (
    .i_mclk(i_mclk), .i_srst(i_srst), .i_sense(i_sense), .i_wr(i_wr),
    .o_high_side_gate(o_high_side_gate), .o_low_side_gate(o_low_side_gate),
    .o_discharge(o_discharge), .o_pgood_oe_n(o_pgood_oe_n));
`default_nettype wire

// ### tb.sv
// self-checking bench for the buck start-up and protection sequencer
`timescale 1ns/1ps
`default_nettype none
`include "buck_seq_consts.svh"
module tb;
    import buck_seq_pkg::*;
    localparam int TK = 2;
    logic i_mclk = 1'b0;
    logic i_srst = 1'b1;
    logic i_enable_pin = 1'b0;
    logic i_wr = 1'b0;
    logic i_rd = 1'b0;
    logic [3:0] i_addr = 4'h0;
    logic [15:0] i_wdata = 16'h0;
    logic [7:0] i_duty = 8'h80;
    logic [15:0] o_rdata;
    logic [15:0] d;
    logic hs;
    logic ls;
    logic dis;
    logic pg_out;
    logic pg_oe_n;
    logic pin;
    logic zc;
    logic [9:0] ref_lvl;
    sense_s sn = '0;
    sense_s sense;
    int error_cnt = 0;
    int check_count = 0;
    int cyc = 0;
    // zero-crossing comes from the power stage, the rest from the bench
    assign sense = {sn[9:2], zc, sn[0]};
    buck_seq #(.TICK_CYCLES(TK)) dut (
        .i_mclk(i_mclk), .i_srst(i_srst), .i_enable_pin(i_enable_pin), .i_sense(sense),
        .i_duty(i_duty), .i_pgood_pin(pin), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_high_side_gate(hs),
        .o_low_side_gate(ls), .o_discharge(dis), .o_ref_level(ref_lvl),
        .o_pgood_out(pg_out), .o_pgood_oe_n(pg_oe_n));
    power_stage_model psm (
        .i_mclk(i_mclk), .i_low_side_gate(ls), .i_pgood_out(pg_out),
        .i_pgood_oe_n(pg_oe_n), .o_pgood_pin(pin), .o_zero_cross(zc));
    always #12.5 i_mclk = ~i_mclk;
    task automatic conclude();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    // ceiling well above the longest path, which is the hiccup wait
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 60000) begin
            error_cnt++;
            conclude();
        end
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge i_mclk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge i_mclk);
        i_wr <= 1'b1;
        i_addr <= a;
        i_wdata <= v;
        @(posedge i_mclk);
        i_wr <= 1'b0;
    endtask
    // data are taken at the edge that ends their only valid cycle
    task automatic rd(input logic [3:0] a);
        @(posedge i_mclk);
        i_rd <= 1'b1;
        i_addr <= a;
        @(posedge i_mclk);
        i_rd <= 1'b0;
        @(posedge i_mclk);
        d = o_rdata;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] m, input logic [15:0] e);
        rd(a);
        chk(d & m, e);
    endtask
    task automatic wseq(input seq_e s, input int n);
        int k;
        k = 0;
        rd(`ADDR_STATE);
        while (d[6:0] !== s && k < n) begin
            rd(`ADDR_STATE);
            k++;
        end
        chk({9'h0, d[6:0]}, {9'h0, s});
    endtask
    task automatic wfor(ref logic s, input logic v, input int n);
        int k;
        k = 0;
        while (s !== v && k < n) begin
            @(posedge i_mclk);
            k++;
        end
        chk(16'(s), 16'(v));
    endtask
    initial begin
        logic e;
        tk(3);
        i_srst <= 1'b0;
        rdc(`ADDR_CTRL, 16'hffff, 16'h0008);
        rdc(`ADDR_STATUS, 16'hffff, 16'h0000);
        rdc(4'h9, 16'hffff, 16'h0000);
        wr(`ADDR_CONFIG, 16'h07ff);
        rdc(`ADDR_CONFIG, 16'hffff, 16'h07ff);
        wr(`ADDR_CONFIG, 16'h0000);
        chk(16'(dis), 16'h1);
        // every start mode against every pin and bit combination
        for (int m = 0; m < 16; m++) begin
            e = m[3] ? (m[2] ? m[0] | m[1] : m[0] & m[1]) : (m[2] ? m[1] : m[0]);
            i_enable_pin <= m[0];
            wr(`ADDR_CTRL, {13'h0, m[3:2], m[1]});
            tk(4);
            chk(16'(dis), 16'(!e));
        end
        i_enable_pin <= 1'b0;
        wr(`ADDR_CTRL, 16'h0008);
        tk(4);
        sn.fb_below_ref <= 1'b1;
        sn.in_inner <= 1'b1;
        wr(`ADDR_CTRL, 16'h000b);
        tk(600);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_DELAY});
        chk(16'(ref_lvl), 16'h0000);
        wseq(SEQ_RAMP, 60);
        tk(1850);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_RAMP});
        chk(16'(ref_lvl[9:8]), 16'h0003);
        wseq(SEQ_RUN, 60);
        chk(16'(ref_lvl[9]), 16'h1);
        chk(16'(pin), 16'h0);
        tk(400);
        chk(16'(pin), 16'h0);
        wfor(pg_oe_n, 1'b1, 200);
        rdc(`ADDR_STATE, 16'h3000, 16'h3000);
        sn.in_inner <= 1'b0;
        sn.out_outer <= 1'b1;
        wfor(pg_oe_n, 1'b0, 10);
        sn.out_outer <= 1'b0;
        // on-time is half the 275 kHz period at this duty
        wfor(hs, 1'b1, 200);
        tk(68);
        chk(16'(hs), 16'h1);
        tk(8);
        chk(16'(hs), 16'h0);
        sn.fb_below_ref <= 1'b0;
        wfor(ls, 1'b1, 5);
        tk(17);
        chk(16'(ls), 16'h1);
        wfor(ls, 1'b0, 8);
        sn.fb_below_ref <= 1'b1;
        wfor(ls, 1'b1, 200);
        sn.cur_over_pos <= 1'b1;
        tk(150);
        chk(16'(hs), 16'h0);
        sn.cur_over_pos <= 1'b0;
        rdc(`ADDR_STATUS, 16'h0003, 16'h0003);
        wr(`ADDR_STATUS, 16'h0003);
        rdc(`ADDR_STATUS, 16'h0003, 16'h0000);
        // forced continuous: zero crossing ignored, negative limit ends the low side
        wr(`ADDR_CTRL, 16'h001b);
        wfor(ls, 1'b1, 200);
        sn.fb_below_ref <= 1'b0;
        tk(40);
        chk(16'(ls), 16'h1);
        sn.cur_below_neg <= 1'b1;
        tk(1);
        sn.cur_below_neg <= 1'b0;
        wfor(ls, 1'b0, 3);
        rdc(`ADDR_STATUS, 16'h0003, 16'h0003);
        wr(`ADDR_STATUS, 16'h0003);
        wr(`ADDR_CTRL, 16'h000b);
        sn.fb_below_ref <= 1'b1;
        sn.fb_high_oob <= 1'b1;
        tk(200);
        chk(16'(hs), 16'h0);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_RUN});
        rdc(`ADDR_STATUS, 16'h0020, 16'h0000);
        sn.fb_high_ov <= 1'b1;
        tk(5);
        chk(16'({hs, ls}), 16'h1);
        rdc(`ADDR_STATUS, 16'h0020, 16'h0020);
        sn.fb_high_ov <= 1'b0;
        sn.fb_high_oob <= 1'b0;
        tk(50);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_OVLATCH});
        sn.cur_below_neg <= 1'b1;
        tk(1);
        sn.cur_below_neg <= 1'b0;
        wfor(hs, 1'b1, 5);
        wfor(ls, 1'b1, 90);
        wr(`ADDR_CTRL, 16'h0008);
        tk(3);
        chk(16'({dis, hs, ls}), 16'h4);
        wr(`ADDR_CTRL, 16'h000b);
        tk(10);
        sn.supply_low <= 1'b1;
        tk(3);
        chk(16'({hs, ls}), 16'h0);
        rdc(`ADDR_STATUS, 16'h000c, 16'h000c);
        sn.supply_low <= 1'b0;
        wr(`ADDR_STATUS, 16'h003f);
        wseq(SEQ_RUN, 1000);
        sn.fb_low_uv <= 1'b1;
        tk(1900);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_RUN});
        wseq(SEQ_HICCUP, 60);
        chk(16'({hs, ls}), 16'h0);
        rdc(`ADDR_STATUS, 16'h0010, 16'h0010);
        sn.fb_low_uv <= 1'b0;
        tk(31500);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_HICCUP});
        wseq(SEQ_RAMP, 300);
        sn.fb_low_uv <= 1'b1;
        wseq(SEQ_RUN, 700);
        tk(200);
        rdc(`ADDR_STATE, 16'h007f, {9'h0, SEQ_RUN});
        conclude();
    end
endmodule
`default_nettype wire
